// ===== core/ebs_ext_bus_if.v
// External bus slave interface top: command decoder, buffers, CPU registers, output selector
`timescale 1ns/1ps
`include "ebs_map.vh"
module ebs_ext_bus_if #(
    parameter AW        = 11,
    parameter SYNC_STGS = 3
) (
    input  wire          core_clk_i,
    input  wire          rst_i,
    // External MCU bus pins
    input  wire          chip_select_pin_n_i,
    input  wire          addr_select_line_i,
    input  wire          status_sel_i,
    input  wire          rd_n_i,
    input  wire          wr_n_i,
    input  wire          dma_ack_n_i,
    input  wire          term_count_n_i,
    input  wire [7:0]    data_i,
    output reg  [7:0]    data_o,
    output wire          data_oe_n_o,
    output wire          ext_irq_pin_o,
    output wire          dma_request_pin_o,
    // Internal CPU bus
    input  wire          cpu_sel_i,
    input  wire [2:0]    cpu_addr_i,
    input  wire          cpu_rd_i,
    input  wire          cpu_wr_i,
    input  wire [7:0]    cpu_wdata_i,
    output reg  [7:0]    cpu_rdata_o,
    output wire          cpu_drive_o,
    output wire          cpu_irq_o,
    // Memory-side controls
    input  wire          burst_i,
    input  wire          mem_load_i,
    input  wire [AW-1:0] mem_load_addr_i,
    input  wire [AW-1:0] mem_end_addr_i,
    input  wire          usb_busy_i,
    // Multichannel RAM port
    output wire          ram_req_o,
    output wire          ram_we_o,
    output wire [AW-1:0] ram_addr_o,
    output reg  [7:0]    ram_wdata_o,
    input  wire [7:0]    ram_rdata_i
);
    // Shared 8-bit buffers and CPU registers
    reg  [7:0] tx_buffer_reg;
    reg  [7:0] rx_buffer_reg;
    reg  [7:0] irq_en;
    reg  [7:0] index_reg;
    reg  [7:0] cfg_lo;
    reg  [7:0] cfg_hi;
    reg        rx_buf_full;
    reg        tx_buf_empty;
    reg        mem_tc_seen;
    reg        mem_done_flag;
    reg        rd_lvl_q;
    reg        cs_s1, cs_s2, a0_s1, a0_s2, ak_s1, ak_s2, tc_s1, tc_s2, st_s1, st_s2;
    reg  [7:0] din_s1, din_s2;
    wire       rd_lvl, rd_rise, wr_lvl, wr_rise;
    wire       mc_busy, mc_done, mc_end;
    wire [AW-1:0] mc_addr;
    wire [7:0] irq_src;

    // Strobes are active low; synchronise the raw pin level so rise = strobe end
    ebs_sync #(.STAGES(SYNC_STGS)) u_rd_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .async_i    (rd_n_i),
        .level_o    (rd_lvl),
        .rise_o     (rd_rise)
    );
    ebs_sync #(.STAGES(SYNC_STGS)) u_wr_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .async_i    (wr_n_i),
        .level_o    (wr_lvl),
        .rise_o     (wr_rise)
    );

    // Remaining pins through two flip-flops; data is stable at strobe rise
    always @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            {cs_s1, cs_s2, ak_s1, ak_s2, tc_s1, tc_s2} <= 6'h3f;
            {a0_s1, a0_s2, st_s1, st_s2} <= 4'h0;
            din_s1 <= `EBS_RST_BYTE;
            din_s2 <= `EBS_RST_BYTE;
        end
        else
        begin
            cs_s1  <= chip_select_pin_n_i;
            cs_s2  <= cs_s1;
            a0_s1  <= addr_select_line_i;
            a0_s2  <= a0_s1;
            ak_s1  <= dma_ack_n_i;
            ak_s2  <= ak_s1;
            tc_s1  <= term_count_n_i;
            tc_s2  <= tc_s1;
            st_s1  <= status_sel_i;
            st_s2  <= st_s1;
            din_s1 <= data_i;
            din_s2 <= din_s1;
        end
    end

    // Configuration fields
    wire       exb_on   = cfg_lo[`EBS_CFG_EXB];
    wire [2:0] int_sel  = cfg_lo[`EBS_CFG_INT_LSB +: 3];
    wire       a1_on    = cfg_lo[`EBS_CFG_A1];
    wire [1:0] drq_sel  = cfg_hi[`EBS_CFG_DRQ_LSB +: 2];
    wire       dak_on   = |cfg_hi[`EBS_CFG_DAK_LSB +: 2];
    wire       tc_on    = cfg_hi[`EBS_CFG_TC];
    wire       mc_run   = irq_en[`EBS_EN_MC];
    wire       rxb_en   = irq_en[`EBS_EN_RXB];
    wire       txb_en   = irq_en[`EBS_EN_TXB];

    // Memory rx/tx enable states of the internal memory interface
    wire mem_rx_enable = mc_run & ~mc_busy & ~mc_end;
    wire mem_tx_enable = mc_run & ~mc_busy & ~mc_end;
    wire mem_tx_buf_select = ~txb_en;

    // Command decoder; acknowledge equals chip select with address select low
    wire dak_act  = dak_on & ~ak_s2;
    wire cs_act   = exb_on & ~cs_s2;
    wire cpu_hit  = cs_act & a0_s2 & ~dak_act;
    wire mem_hit  = (cs_act & ~a0_s2) | dak_act;
    wire stt_sel  = cs_act & a1_on & st_s2;
    wire cch_rd   = cpu_hit & rd_rise & txb_en;
    wire cch_wr   = cpu_hit & wr_rise & rxb_en;
    wire mch_rd   = mem_hit & rd_rise & mem_tx_enable;
    wire mch_wr   = mem_hit & wr_rise & mem_rx_enable;
    wire mem_chan_term_count = mch_wr & tc_on & ~tc_s2;
    wire buf_wr   = cch_wr | mch_wr;
    assign data_oe_n_o = ~((cs_act | dak_act) & ~rd_lvl);

    // External read data: status, or transmit buffer
    always @(posedge core_clk_i)
    begin
        if (rst_i)
            data_o <= `EBS_RST_BYTE;
        else
            data_o <= stt_sel ? irq_src : tx_buffer_reg;
    end

    // Memory channel request: per byte, or held for the whole burst
    wire mc_req = burst_i ? (mc_run & ~mc_end)
                          : (mc_run & ~mc_end & ~mc_busy);

    // CPU channel buffer flags
    wire rx_buf_ready = ~rx_buf_full & rxb_en;
    wire tx_buf_ready = ~tx_buf_empty & txb_en;

    // Output selector
    function sel_src;
        input [2:0] sel;
        input       txr, rxr, mcr;
        begin
            if (sel == `EBS_SEL_TXRDY)
                sel_src = txr;
            else if (sel == `EBS_SEL_RXRDY)
                sel_src = rxr;
            else if (sel == `EBS_SEL_MCREQ)
                sel_src = mcr;
            else
                sel_src = 1'b0;
        end
    endfunction
    assign ext_irq_pin_o     = exb_on & sel_src(int_sel, tx_buf_ready, rx_buf_ready, mc_req);
    assign dma_request_pin_o = exb_on & sel_src({1'b0, drq_sel}, tx_buf_ready, rx_buf_ready, mc_req);

    // Memory channel controller
    ebs_mem_ctrl #(.AW(AW)) u_mc (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .start_i     (mch_rd | mch_wr),
        .dir_wr_i    (mch_wr),
        .usb_busy_i  (usb_busy_i),
        .load_i      (mem_load_i),
        .load_addr_i (mem_load_addr_i),
        .end_addr_i  (mem_end_addr_i),
        .run_i       (mc_run),
        .addr_o      (mc_addr),
        .ram_req_o   (ram_req_o),
        .ram_we_o    (ram_we_o),
        .busy_o      (mc_busy),
        .done_o      (mc_done),
        .at_end_o    (mc_end)
    );
    assign ram_addr_o = mc_addr;

    // Interrupt source register, read-only from both sides
    assign irq_src = {3'h0, mem_done_flag, mem_tc_seen, mc_busy, tx_buf_empty, rx_buf_full};
    assign cpu_irq_o = (rx_buf_full & rxb_en) | (tx_buf_empty & txb_en)
                     | (mem_done_flag & mc_run);

    // CPU write strobes, one per register, and the receive buffer read strobe
    wire we_en  = cpu_sel_i & cpu_wr_i & (cpu_addr_i == `EBS_ADDR_IRQ_EN);
    wire we_idx = cpu_sel_i & cpu_wr_i & (cpu_addr_i == `EBS_ADDR_INDEX);
    wire we_w1  = cpu_sel_i & cpu_wr_i & (cpu_addr_i == `EBS_ADDR_WIN1);
    wire we_w2  = cpu_sel_i & cpu_wr_i & (cpu_addr_i == `EBS_ADDR_WIN2);
    wire we_tx  = cpu_sel_i & cpu_wr_i & (cpu_addr_i == `EBS_ADDR_TX_BUFFER_REG);
    wire rd_rx  = cpu_sel_i & cpu_rd_i & (cpu_addr_i == `EBS_ADDR_RX_BUFFER_REG);

    // Registers, buffers and flags; hardware set wins over clear
    always @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            irq_en        <= `EBS_RST_BYTE;
            index_reg     <= `EBS_RST_BYTE;
            cfg_lo        <= `EBS_RST_BYTE;
            cfg_hi        <= `EBS_RST_BYTE;
            tx_buffer_reg <= `EBS_RST_BYTE;
            rx_buffer_reg <= `EBS_RST_BYTE;
            ram_wdata_o   <= `EBS_RST_BYTE;
            rx_buf_full   <= 1'b0;
            tx_buf_empty  <= 1'b1;
            mem_tc_seen   <= 1'b0;
            mem_done_flag <= 1'b0;
            rd_lvl_q      <= 1'b0;
        end
        else
        begin
            rd_lvl_q <= rd_lvl;
            if (we_en)
                irq_en <= cpu_wdata_i;
            if (we_idx)
                index_reg <= cpu_wdata_i;
            // Configuration is reached through the index window
            if (we_w1 && index_reg == `EBS_RST_BYTE)
                cfg_lo <= cpu_wdata_i;
            if (we_w2 && index_reg == `EBS_RST_BYTE)
                cfg_hi <= cpu_wdata_i;
            if (buf_wr)
                rx_buffer_reg <= din_s2;
            if (mch_wr)
                ram_wdata_o <= din_s2;
            // RAM read data lands in the shared transmit buffer
            if (ram_req_o && !ram_we_o && mem_tx_buf_select)
                tx_buffer_reg <= ram_rdata_i;
            else if (we_tx)
                tx_buffer_reg <= cpu_wdata_i;
            if (cch_wr)
                rx_buf_full <= 1'b1;
            else if (rd_rx)
                rx_buf_full <= 1'b0;
            if (cch_rd)
                tx_buf_empty <= 1'b1;
            else if (we_tx)
                tx_buf_empty <= 1'b0;
            if (mem_chan_term_count)
                mem_tc_seen <= 1'b1;
            else if (we_en && !cpu_wdata_i[`EBS_EN_MC])
                mem_tc_seen <= 1'b0;
            if ((mc_done && mc_end) || mem_chan_term_count)
                mem_done_flag <= 1'b1;
            else if (we_en)
                mem_done_flag <= 1'b0;
        end
    end

    // CPU read mux; drivers enabled by select and read
    assign cpu_drive_o = cpu_sel_i & cpu_rd_i;
    always @*
    begin
        if (cpu_addr_i == `EBS_ADDR_IRQ_SRC)
            cpu_rdata_o = irq_src;
        else if (cpu_addr_i == `EBS_ADDR_IRQ_EN)
            cpu_rdata_o = irq_en;
        else if (cpu_addr_i == `EBS_ADDR_INDEX)
            cpu_rdata_o = index_reg;
        else if (cpu_addr_i == `EBS_ADDR_WIN1)
            cpu_rdata_o = (index_reg == `EBS_RST_BYTE) ? cfg_lo : 8'h00;
        else if (cpu_addr_i == `EBS_ADDR_WIN2)
            cpu_rdata_o = (index_reg == `EBS_RST_BYTE) ? cfg_hi : 8'h00;
        else if (cpu_addr_i == `EBS_ADDR_RX_BUFFER_REG)
            cpu_rdata_o = rx_buffer_reg;
        else if (cpu_addr_i == `EBS_ADDR_TX_BUFFER_REG)
            cpu_rdata_o = tx_buffer_reg;
        else
            cpu_rdata_o = 8'h00;
    end
endmodule // ebs_ext_bus_if

// ===== core/ebs_map.vh
// Register map, field positions and timing counts of the external bus slave interface
// Function
// - Memory access: sync strobe rise, then move buffer and RAM in two clocks.
// - USB has RAM priority; memory transfer may wait up to two more clocks; the code waits in S_WAIT for as long as usb_busy_i is high, with no limit.
// - Burst bit in memory mode register gives highest-rate memory transfers.
// - CPU channel transfers are carried by interrupts to the internal CPU.
// - Memory channel moves data to RAM by direct access, no CPU involvement.
// - Command decoder makes channel strobes, terminal count, buffer write, status select, output enable.
// - CPU channel access gated by configuration register and the rx/tx buffer enable bits.
// - Memory access gated by configuration register and memory rx/tx enable states.
// - Selector routes tx ready, rx ready or memory request to irq and DMA pins.
// - Each CPU-writable register gets its own write strobe from decode and write.
// - CPU read drivers enabled by module select and read; decode picks register.
// - Four CPU-writable registers: enable, index, configuration, transmit buffer; source register read-only.
// - Status from both channel controllers is presented to the internal CPU.
// - Rx full/ready and tx empty/ready derive from CPU channel strobes.
// - Address select high addresses the CPU channel and raises an interrupt.
// - Address select low accesses RAM at an auto-incrementing address.
// - DMA acknowledge low acts as chip select and address select low.
// - Both channels share one 8-bit transmit and one 8-bit receive buffer.
`ifndef EBS_MAP_VH
`define EBS_MAP_VH
// CPU-side register addresses
`define EBS_ADDR_IRQ_SRC      3'h0
`define EBS_ADDR_IRQ_EN       3'h1
`define EBS_ADDR_INDEX        3'h2
`define EBS_ADDR_WIN1         3'h3
`define EBS_ADDR_WIN2         3'h4
`define EBS_ADDR_TX_BUFFER_REG        3'h5
`define EBS_ADDR_RX_BUFFER_REG        3'h6
// Interrupt source enable fields
`define EBS_EN_RXB            0
`define EBS_EN_TXB            1
`define EBS_EN_MC             2
// Configuration register low fields
`define EBS_CFG_EXB           0
`define EBS_CFG_INT_LSB       1
`define EBS_CFG_A1            4
// Configuration register high fields
`define EBS_CFG_DRQ_LSB       0
`define EBS_CFG_DAK_LSB       2
`define EBS_CFG_TC            4
// Output selector codes
`define EBS_SEL_TXRDY         3'h0
`define EBS_SEL_RXRDY         3'h1
`define EBS_SEL_MCREQ         3'h2
// Reset values
`define EBS_RST_BYTE          8'h00
// Timing: RAM move time and USB wait in clocks
`define EBS_XFER_CLKS         2
`define EBS_USB_WAIT_CLKS     2
`endif

// ===== core/ebs_sync.v
// Multi-stage synchroniser with rising-edge pulse output
`timescale 1ns/1ps
module ebs_sync #(
    parameter STAGES = 3
) (
    input  wire core_clk_i,
    input  wire rst_i,
    input  wire async_i,
    output wire level_o,
    output wire rise_o
);
    reg [STAGES-1:0] chain;
    reg              last;

    // First stage feeds only the second; extra stage lowers MTBF risk
    always @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            // Idle strobe level is high; avoids a false edge after reset
            chain <= {STAGES{1'b1}};
            last  <= 1'b1;
        end
        else
        begin
            chain <= {chain[STAGES-2:0], async_i};
            last  <= chain[STAGES-1];
        end
    end

    assign level_o = chain[STAGES-1];
    assign rise_o  = chain[STAGES-1] & ~last;
endmodule // ebs_sync

// ===== core/ebs_mem_ctrl.v
// Memory channel controller: RAM move sequencer with USB arbitration and address counter
`timescale 1ns/1ps
`include "ebs_map.vh"
module ebs_mem_ctrl #(
    parameter AW = 11
) (
    input  wire          core_clk_i,
    input  wire          rst_i,
    input  wire          start_i,
    input  wire          dir_wr_i,
    input  wire          usb_busy_i,
    input  wire          load_i,
    input  wire [AW-1:0] load_addr_i,
    input  wire [AW-1:0] end_addr_i,
    input  wire          run_i,
    output reg  [AW-1:0] addr_o,
    output wire          ram_req_o,
    output wire          ram_we_o,
    output reg           busy_o,
    output reg           done_o,
    output reg           at_end_o
);
    localparam S_IDLE = 2'h0;
    localparam S_WAIT = 2'h1;
    localparam S_XFER = 2'h2;
    localparam [1:0] XFER_LAST = `EBS_XFER_CLKS - 1;

    reg [1:0] state;
    reg [1:0] next_state;
    reg       dir_wr;
    reg [1:0] cnt;

    // USB owns the RAM while busy; we retry each cycle
    always @*
    begin
        next_state = state;
        case (state)
            S_IDLE:  if (start_i) next_state = usb_busy_i ? S_WAIT : S_XFER;
            S_WAIT:  if (!usb_busy_i) next_state = S_XFER;
            S_XFER:  if (cnt == XFER_LAST) next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    always @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            state    <= S_IDLE;
            dir_wr   <= 1'b0;
            cnt      <= 2'h0;
            addr_o   <= {AW{1'b0}};
            busy_o   <= 1'b0;
            done_o   <= 1'b0;
            at_end_o <= 1'b0;
        end
        else
        begin
            state  <= next_state;
            done_o <= 1'b0;
            busy_o <= (next_state != S_IDLE);
            if (state == S_IDLE && start_i)
                dir_wr <= dir_wr_i;
            cnt <= (state == S_XFER) ? cnt + 2'h1 : 2'h0;
            // Address loads only while the channel is stopped
            if (load_i && !run_i)
            begin
                addr_o   <= load_addr_i;
                at_end_o <= 1'b0;
            end
            else if (state == S_XFER && next_state == S_IDLE)
            begin
                addr_o   <= addr_o + 1'b1;
                at_end_o <= (addr_o == end_addr_i);
                done_o   <= 1'b1;
            end
        end
    end

    assign ram_req_o = (state == S_XFER);
    assign ram_we_o  = (state == S_XFER) & dir_wr;
endmodule // ebs_mem_ctrl

// ===== sim/ebs_ext_bus_if_props.sv
// Port-level assertions for the external bus slave interface
`timescale 1ns/1ps
module ebs_ext_bus_if_props #(
    parameter AW = 11
) (
    input wire          core_clk_i,
    input wire          rst_i,
    input wire          chip_select_pin_n_i,
    input wire          rd_n_i,
    input wire          data_oe_n_o,
    input wire          cpu_sel_i,
    input wire [2:0]    cpu_addr_i,
    input wire          cpu_rd_i,
    input wire [7:0]    cpu_rdata_o,
    input wire          cpu_drive_o,
    input wire          mem_load_i,
    input wire          usb_busy_i,
    input wire          ram_req_o,
    input wire          ram_we_o,
    input wire [AW-1:0] ram_addr_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // One RAM move: request held, then dropped
    sequence s_move;
        ram_req_o ##1 !ram_req_o;
    endsequence
    // Read strobe held long enough to cross the synchroniser
    sequence s_rd_held;
        (!rd_n_i && !chip_select_pin_n_i) [*6];
    endsequence

    chk_move_two : assert property ($rose(ram_req_o) |=> s_move)
        else $error("ram request not two cycles long");
    chk_usb_first : assert property (usb_busy_i [*3] |-> !ram_req_o)
        else $error("ram request while usb holds the ram");
    chk_we_in_req : assert property (ram_we_o |-> ram_req_o)
        else $error("ram write outside a request");
    chk_addr_step : assert property ($changed(ram_addr_o) && !$past(mem_load_i) |-> ram_addr_o == $past(ram_addr_o) + 1'b1)
        else $error("ram address moved other than by one");
    chk_drive_en : assert property (cpu_drive_o == (cpu_sel_i && cpu_rd_i))
        else $error("cpu drive enable wrong");
    chk_hole_zero : assert property (cpu_sel_i && cpu_rd_i && cpu_addr_i == 3'h7 |-> cpu_rdata_o == 8'h00)
        else $error("unmapped cpu address not zero");
    chk_oe_drive : assert property (s_rd_held |-> !data_oe_n_o)
        else $error("data not driven during read");
    chk_oe_idle : assert property (rd_n_i [*6] |-> data_oe_n_o)
        else $error("data driven without read");
endmodule // ebs_ext_bus_if_props

bind ebs_ext_bus_if ebs_ext_bus_if_props #(.AW(AW)) u_props (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .chip_select_pin_n_i(chip_select_pin_n_i),
    .rd_n_i(rd_n_i), .data_oe_n_o(data_oe_n_o), .cpu_sel_i(cpu_sel_i), .cpu_addr_i(cpu_addr_i),
    .cpu_rd_i(cpu_rd_i), .cpu_rdata_o(cpu_rdata_o), .cpu_drive_o(cpu_drive_o),
    .mem_load_i(mem_load_i), .usb_busy_i(usb_busy_i), .ram_req_o(ram_req_o),
    .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o)
);

// ===== sim/ebs_mcu_model.sv
// Behavioural external bus master for the slave pins
`timescale 1ns/1ps
module ebs_mcu_model (
    input  wire       core_clk_i,
    input  wire [7:0] data_i,
    output reg        cs_n_o,
    output reg        a0_o,
    output reg        st_sel_o,
    output reg        rd_n_o,
    output reg        wr_n_o,
    output reg        dma_ack_n_o,
    output reg        tc_n_o,
    output reg  [7:0] data_o
);
    // Idle bus at time zero
    initial
    begin
        cs_n_o = 1'b1;
        a0_o = 1'b0;
        st_sel_o = 1'b0;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        dma_ack_n_o = 1'b1;
        tc_n_o = 1'b1;
        data_o = 8'h00;
    end

    // One bus cycle; select, address and data outlive the strobe rise
    task xfer(input wr, input a0, input dk, input st, input [7:0] d, output [7:0] q);
        begin
            @(posedge core_clk_i);
            #1;
            a0_o = a0;
            st_sel_o = st;
            cs_n_o = dk;
            dma_ack_n_o = !dk;
            data_o = d;
            wr_n_o = !wr;
            rd_n_o = wr;
            repeat (6) @(posedge core_clk_i);
            q = data_i;
            #1;
            wr_n_o = 1'b1;
            rd_n_o = 1'b1;
            repeat (4) @(posedge core_clk_i);
            #1;
            cs_n_o = 1'b1;
            dma_ack_n_o = 1'b1;
            // Released lines no longer show the old level
            a0_o = !a0;
            data_o = ~d;
            // Gap covers sync, the move and a usb wait
            repeat (12) @(posedge core_clk_i);
            #1;
        end
    endtask
endmodule // ebs_mcu_model

// ===== sim/ebs_ext_bus_if_tb.sv
// Directed bench for the external bus slave interface
`timescale 1ns/1ps
module ebs_ext_bus_if_tb;
    logic        core_clk_i, rst_i, cpu_sel_i, cpu_rd_i, cpu_wr_i, mem_load_i, usb_busy_i, p0, burst;
    logic [2:0]  cpu_addr_i;
    logic [7:0]  cpu_wdata_i, wr_data, q;
    logic [10:0] mem_load_addr_i, wr_addr;
    wire         cs_n, a0, st_sel, rd_n, wr_n, dma_ack_n, tc_n, data_oe_n_o, ext_irq_pin_o;
    wire         dma_request_pin_o, cpu_drive_o, cpu_irq_o, ram_req_o, ram_we_o;
    wire [7:0]   mdata, data_o, cpu_rdata_o, ram_wdata_o;
    wire [10:0]  ram_addr_o;
    integer      n_fail = 0, cmp_count = 0, n_req = 0, cyc = 0, n0, i;

    ebs_ext_bus_if #(.AW(11), .SYNC_STGS(3)) DUT (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .chip_select_pin_n_i(cs_n),
        .addr_select_line_i(a0), .status_sel_i(st_sel), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .dma_ack_n_i(dma_ack_n), .term_count_n_i(tc_n), .data_i(mdata), .data_o(data_o),
        .data_oe_n_o(data_oe_n_o), .ext_irq_pin_o(ext_irq_pin_o), .dma_request_pin_o(dma_request_pin_o),
        .cpu_sel_i(cpu_sel_i), .cpu_addr_i(cpu_addr_i), .cpu_rd_i(cpu_rd_i), .cpu_wr_i(cpu_wr_i),
        .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o), .cpu_drive_o(cpu_drive_o),
        .cpu_irq_o(cpu_irq_o), .burst_i(burst), .mem_load_i(mem_load_i),
        .mem_load_addr_i(mem_load_addr_i), .mem_end_addr_i(11'h020), .usb_busy_i(usb_busy_i),
        .ram_req_o(ram_req_o), .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o),
        .ram_wdata_o(ram_wdata_o), .ram_rdata_i(ram_addr_o[7:0] ^ 8'h5a)
    );
    ebs_mcu_model mcu (
        .core_clk_i(core_clk_i), .data_i(data_o), .cs_n_o(cs_n), .a0_o(a0), .st_sel_o(st_sel),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .dma_ack_n_o(dma_ack_n), .tc_n_o(tc_n), .data_o(mdata)
    );

    // 200 MHz clock
    initial
    begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    // RAM port monitor and hang guard
    always @(posedge core_clk_i)
    begin
        cyc <= cyc + 1;
        if (ram_req_o)
            n_req <= n_req + 1;
        if (ram_we_o)
        begin
            wr_addr <= ram_addr_o;
            wr_data <= ram_wdata_o;
        end
        if (cyc == 3000)
        begin
            n_fail = n_fail + 1;
            end_of_test;
        end
    end

    task chk(input [15:0] exp, input [15:0] got, input string what);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp)
            begin
                $display("[FAIL] %0s expected %h seen %h", what, exp, got);
                n_fail = n_fail + 1;
            end
        end
    endtask

    // CPU bus cycles, entered just after an edge
    task cpu_wr(input [2:0] a, input [7:0] d);
        begin
            cpu_addr_i = a;
            cpu_wdata_i = d;
            cpu_sel_i = 1'b1;
            cpu_wr_i = 1'b1;
            @(posedge core_clk_i);
            #1;
            cpu_sel_i = 1'b0;
            cpu_wr_i = 1'b0;
        end
    endtask

    task cpu_rd(input [2:0] a, input [7:0] exp);
        begin
            cpu_addr_i = a;
            cpu_sel_i = 1'b1;
            cpu_rd_i = 1'b1;
            #1;
            chk(exp, cpu_rdata_o, "cpu read data");
            @(posedge core_clk_i);
            #1;
            cpu_sel_i = 1'b0;
            cpu_rd_i = 1'b0;
        end
    endtask

    task t_regs;
        begin
            cpu_wr(3'h1, 8'h03);
            cpu_rd(3'h1, 8'h03);
            cpu_wr(3'h2, 8'h05);
            cpu_rd(3'h2, 8'h05);
            cpu_wr(3'h2, 8'h00);
            cpu_wr(3'h3, 8'h1f);
            cpu_rd(3'h3, 8'h1f);
            cpu_wr(3'h4, 8'h1f);
            cpu_rd(3'h4, 8'h1f);
            cpu_rd(3'h7, 8'h00);
            $display("test regs done");
        end
    endtask

    task t_cpu_wr;
        begin
            cpu_wr(3'h1, 8'h01);
            cpu_wr(3'h3, 8'h03);
            cpu_wr(3'h4, 8'h01);
            p0 = ext_irq_pin_o;
            mcu.xfer(1, 1, 0, 0, 8'ha5, q);
            chk(1, cpu_irq_o, "cpu irq");
            chk(!p0, ext_irq_pin_o, "irq pin");
            chk(ext_irq_pin_o, dma_request_pin_o, "dreq pin");
            cpu_rd(3'h6, 8'ha5);
            chk(0, cpu_irq_o, "cpu irq");
            $display("test cpu write done");
        end
    endtask

    task t_cpu_rd;
        begin
            cpu_wr(3'h1, 8'h02);
            cpu_wr(3'h3, 8'h11);
            cpu_wr(3'h5, 8'h3c);
            chk(0, cpu_irq_o, "cpu irq");
            p0 = ext_irq_pin_o;
            mcu.xfer(0, 1, 0, 0, 8'h00, q);
            chk(8'h3c, q, "ext read data");
            chk(1, cpu_irq_o, "cpu irq");
            chk(!p0, ext_irq_pin_o, "irq pin");
            mcu.xfer(0, 1, 0, 1, 8'h00, q);
            chk(8'h02, q, "status byte");
            $display("test cpu read done");
        end
    endtask

    task t_mem;
        begin
            cpu_wr(3'h1, 8'h00);
            mem_load_addr_i = 11'h010;
            mem_load_i = 1'b1;
            @(posedge core_clk_i);
            #1;
            mem_load_i = 1'b0;
            cpu_wr(3'h3, 8'h01);
            cpu_wr(3'h4, 8'h04);
            n0 = n_req;
            mcu.xfer(1, 0, 0, 0, 8'h11, q);
            chk(n0, n_req, "gated move");
            cpu_wr(3'h1, 8'h04);
            cpu_wr(3'h4, 8'h06);
            // Plain select, dma acknowledge, then usb holding the ram in burst mode
            for (i = 0; i < 3; i = i + 1)
            begin
                n0 = n_req;
                usb_busy_i = (i == 2);
                burst = (i == 2);
                mcu.xfer(1, 0, i == 1, 0, 8'h60 + i, q);
                chk(n0 + (i == 2 ? 0 : 2), n_req, "usb wait");
                chk(1, dma_request_pin_o, "mem request");
                usb_busy_i = 1'b0;
                burst = 1'b0;
                repeat (8) @(posedge core_clk_i);
                #1;
                chk(n0 + 2, n_req, "move cycles");
                chk(8'h60 + i, wr_data, "ram data");
                chk(11'h010 + i, wr_addr, "ram addr");
                chk(11'h011 + i, ram_addr_o, "next addr");
            end
            n0 = n_req;
            mcu.xfer(0, 0, 0, 0, 8'h00, q);
            chk(n0 + 2, n_req, "read move");
            chk(11'h012, wr_addr, "no ram write");
            chk(11'h014, ram_addr_o, "next addr");
            $display("test memory done");
        end
    endtask

    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
            if (n_fail == 0 && cmp_count > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    // Reset, then the scenarios in order
    initial
    begin
        rst_i = 1'b1;
        cpu_sel_i = 1'b0;
        cpu_rd_i = 1'b0;
        cpu_wr_i = 1'b0;
        cpu_addr_i = 3'h0;
        cpu_wdata_i = 8'h00;
        mem_load_i = 1'b0;
        mem_load_addr_i = 11'h000;
        usb_busy_i = 1'b0;
        burst = 1'b0;
        repeat (8) @(posedge core_clk_i);
        #1;
        rst_i = 1'b0;
        repeat (4) @(posedge core_clk_i);
        #1;
        t_regs;
        t_cpu_wr;
        t_cpu_rd;
        t_mem;
        end_of_test;
    end
endmodule // ebs_ext_bus_if_tb
